// ==== hw/cmoi_can_core.sv ====
`include "cmoi_map.svh"
`default_nettype none
module cmoi_can_core #(
    parameter int NOBJ = 15
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wdt_rst,
    input wire logic [`CMOI_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rx_pin,
    input wire logic eng_tx_bit,
    input wire logic eng_tx_done,
    input wire logic eng_tx_err,
    input wire logic eng_rx_err,
    input wire cmoi_pkg::cmoi_rxfrm_t eng_rx,
    output var cmoi_pkg::cmoi_txreq_t eng_tx_req,
    output logic bus_transmit_output,
    output logic bus_on,
    output logic bit_sample
);
    import cmoi_pkg::*;

    // ****************************************
    // reset and storage
    // ****************************************
    logic wdt_q;
    logic rst_int;
    logic [7:0] ctrl_q;
    logic [2:0] lec_q;
    logic [14:0] bt_q;
    logic [8:0] tec_q;
    logic [7:0] rec_q;
    logic busoff_q;
    logic [7:0] rec_cnt_q;
    cmoi_state_t state_q;
    logic [5:0] brp_cnt_q;
    logic [4:0] tq_cnt_q;
    logic sample_q;
    logic [3:0] run_q;
    logic txd_q;
    logic bus_on_q;
    cmoi_txreq_t tx_req_q;
    logic waitreq_q;
    logic [31:0] readdata_q;
    logic [NOBJ:1] valid_q, transmit_request_q, remote_pending_q, new_data_flag_q;
    logic sel_q, altp_q;
    logic [7:0] cfg_q [1:NOBJ];
    logic [28:0] arb_q [1:NOBJ];
    logic [7:0] db_q [0:NOBJ][0:7];

    // watchdog request retimed so the combined reset is glitch free
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdt_q <= 1'b0;
        end else begin
            wdt_q <= wdt_rst;
        end
    end
    assign rst_int = rst | wdt_q;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [3:0] lowest_set(input logic [NOBJ:1] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = NOBJ; i >= 1; i--) begin
            if (v[i]) r = 4'(i);
        end
        return r;
    endfunction

    // last object maps to one of two banks, others to their own
    function automatic logic [3:0] bank(input logic [3:0] o, input logic alt);
        if (o == 4'(NOBJ)) return (sel_q ^ alt) ? 4'h0 : 4'(NOBJ);
        return o;
    endfunction

    function automatic logic [3:0] clamp_dlc(input logic [3:0] d);
        return (d > `CMOI_DLC_MAX) ? `CMOI_DLC_MAX : d;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) r[b*8 +: 8] = n[b*8 +: 8];
        end
        return r;
    endfunction

    default clocking @(posedge clk); endclocking
    default disable iff (rst_int);

    // ****************************************
    // avalon slave decode
    // ****************************************
    logic [7:0] idx;
    logic [3:0] obj_idx, sub;
    logic acc, wr, obj_sel;
    logic init_q, cce_q;
    assign idx = avs_address[9:2];
    assign obj_idx = idx[7:4];
    assign sub = idx[3:0];
    assign acc = (avs_read | avs_write) & ~waitreq_q;
    assign wr = avs_write & acc;
    assign obj_sel = (obj_idx != 4'h0) && (obj_idx <= 4'(NOBJ));
    assign init_q = ctrl_q[`CMOI_CTRL_INIT];
    assign cce_q = ctrl_q[`CMOI_CTRL_CCE];

    // read mux, unmapped reads zero
    logic [31:0] rd_d;
    always_comb begin
        rd_d = 32'h0;
        if (!obj_sel) begin
            case (idx)
                `CMOI_IDX_CTRL: rd_d = {20'h0, busoff_q, lec_q, ctrl_q};
                `CMOI_IDX_BTIME: rd_d = {17'h0, bt_q};
                `CMOI_IDX_ERRCNT: rd_d = {8'h0, rec_q, 7'h0, tec_q};
                default: rd_d = 32'h0;
            endcase
        end else if (sub == `CMOI_SUB_OBJCTL) begin
            rd_d = {28'h0, new_data_flag_q[obj_idx], remote_pending_q[obj_idx], transmit_request_q[obj_idx],
                    valid_q[obj_idx]};
        end else if (sub == `CMOI_SUB_ARB) begin
            rd_d = {3'h0, arb_q[obj_idx]};
        end else if (sub == `CMOI_SUB_CFG) begin
            rd_d = {24'h0, cfg_q[obj_idx]};
        end else if (sub >= `CMOI_SUB_DB0 && sub <= `CMOI_SUB_DB7) begin
            rd_d = {24'h0, db_q[bank(obj_idx, 1'b0)][3'(sub - `CMOI_SUB_DB0)]};
        end
    end

    // one wait cycle, then the answer stands for the accepting edge
    always_ff @(posedge clk or posedge rst_int) begin
        if (rst_int) begin
            waitreq_q <= 1'b1;
            readdata_q <= 32'h0;
        end else if ((avs_read | avs_write) && waitreq_q) begin
            waitreq_q <= 1'b0;
            readdata_q <= rd_d;
        end else begin
            waitreq_q <= 1'b1;
        end
    end

    AST_WAIT_ONE: assert property ((avs_read | avs_write) && waitreq_q |=> !waitreq_q)
        else $error("waitrequest did not drop after one cycle");

    // ****************************************
    // control and bit timing registers
    // ****************************************
    logic idle_evt, recov_done, busoff_entry;
    assign busoff_entry = (state_q == ST_RUN) && tec_q[8];

    // init set by reset value, software and busoff entry
    always_ff @(posedge clk or posedge rst_int) begin
        if (rst_int) begin
            ctrl_q <= `CMOI_CTRL_RST;
            lec_q <= 3'h0;
        end else begin
            if (wr && idx == `CMOI_IDX_CTRL && avs_byteenable[0]) ctrl_q <= avs_writedata[7:0];
            if (wr && idx == `CMOI_IDX_CTRL && avs_byteenable[1]) lec_q <= avs_writedata[10:8];
            if (busoff_entry) ctrl_q[`CMOI_CTRL_INIT] <= 1'b1;
            if (state_q == ST_RECOV && idle_evt) lec_q <= `CMOI_LEC_BIT0;
        end
    end

    // bit timing survives watchdog reset, locked outside config mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bt_q <= `CMOI_BT_RST;
        end else if (wr && idx == `CMOI_IDX_BTIME && init_q && cce_q) begin
            bt_q <= 15'(merge({17'h0, bt_q}, avs_writedata, avs_byteenable));
        end
    end

    AST_BT_LOCK: assert property (wr && idx == `CMOI_IDX_BTIME && !(init_q && cce_q)
                                  |=> $stable(bt_q))
        else $error("bit timing changed outside config mode");
    AST_BUSOFF_INIT: assert property (busoff_entry |=> init_q && busoff_q)
        else $error("busoff entry did not set init");

    // ****************************************
    // quantum and bit timing
    // ****************************************
    logic tq_tick;
    logic [4:0] sample_tq, last_tq;
    assign tq_tick = brp_cnt_q >= bt_q[`CMOI_BT_BRP];
    assign sample_tq = {1'b0, bt_q[`CMOI_BT_SEGMENT_BEFORE_SAMPLE]} + 5'h01;
    assign last_tq = sample_tq + {2'h0, bt_q[`CMOI_BT_SEGMENT_AFTER_SAMPLE]} + 5'h01;

    // quantum 0 is sync, sample at end of first segment
    always_ff @(posedge clk or posedge rst_int) begin
        if (rst_int) begin
            brp_cnt_q <= 6'h00;
            tq_cnt_q <= 5'h00;
            sample_q <= 1'b0;
        end else begin
            sample_q <= tq_tick && (tq_cnt_q == sample_tq);
            if (tq_tick) begin
                brp_cnt_q <= 6'h00;
                tq_cnt_q <= (tq_cnt_q >= last_tq) ? 5'h00 : tq_cnt_q + 5'h01;
            end else begin
                brp_cnt_q <= brp_cnt_q + 6'h01;
            end
        end
    end

    AST_SAMPLE_POINT: assert property (sample_q |-> $past(tq_cnt_q) == sample_tq)
        else $error("sample point not at end of first segment");

    // ****************************************
    // bus idle detection
    // ****************************************
    assign idle_evt = sample_q && rx_pin && !init_q && run_q == `CMOI_IDLE_BITS - 4'h1;

    // counts recessive samples, restarts after each eleven
    always_ff @(posedge clk or posedge rst_int) begin
        if (rst_int) begin
            run_q <= 4'h0;
        end else if (init_q) begin
            run_q <= 4'h0;
        end else if (sample_q) begin
            run_q <= (!rx_pin || idle_evt) ? 4'h0 : run_q + 4'h1;
        end
    end

    AST_IDLE_RUN: assert property (idle_evt |-> !init_q && run_q == 4'hA)
        else $error("idle flagged without ten prior recessive samples");

    // ****************************************
    // sequencing and busoff recovery
    // ****************************************
    assign recov_done = state_q == ST_RECOV && idle_evt && rec_cnt_q == `CMOI_RECOVER_IDLES - 8'h1;

    always_ff @(posedge clk or posedge rst_int) begin
        if (rst_int) begin
            state_q <= ST_INIT;
            busoff_q <= 1'b0;
            rec_cnt_q <= 8'h00;
        end else begin
            case (state_q)
                ST_INIT: begin
                    if (!init_q) state_q <= busoff_q ? ST_RECOV : ST_SYNC;
                end
                ST_SYNC: begin
                    if (init_q) state_q <= ST_INIT;
                    else if (idle_evt) state_q <= ST_RUN;
                end
                ST_RUN: begin
                    if (busoff_entry) begin
                        busoff_q <= 1'b1;
                        rec_cnt_q <= 8'h00;
                        state_q <= ST_RECOV;
                    end else if (init_q) begin
                        state_q <= ST_INIT;
                    end
                end
                ST_RECOV: begin
                    // init only pauses the count, never restarts it
                    if (recov_done) begin
                        busoff_q <= 1'b0;
                        state_q <= ST_RUN;
                    end else if (idle_evt) begin
                        rec_cnt_q <= rec_cnt_q + 8'h01;
                    end
                end
                default: state_q <= ST_INIT;
            endcase
        end
    end

    AST_RECOV_LEC: assert property (state_q == ST_RECOV && idle_evt |=> lec_q == 3'h5)
        else $error("idle during recovery did not write error code");
    AST_RECOV_END: assert property (recov_done |=> state_q == ST_RUN && tec_q == 9'h0
                                    && rec_q == 8'h0 && !busoff_q)
        else $error("recovery end did not clear counters");
    AST_RECOV_HOLD: assert property (state_q == ST_RECOV && init_q |=> $stable(rec_cnt_q))
        else $error("recovery count moved while init set");

    // ****************************************
    // error counters
    // ****************************************
    always_ff @(posedge clk or posedge rst_int) begin
        if (rst_int) begin
            tec_q <= 9'h000;
            rec_q <= 8'h00;
        end else if (recov_done) begin
            tec_q <= 9'h000;
            rec_q <= 8'h00;
        end else if (state_q == ST_RUN && !init_q) begin
            if (eng_tx_err) begin
                tec_q <= (tec_q > `CMOI_TEC_BUSOFF - `CMOI_TEC_STEP) ? `CMOI_TEC_BUSOFF
                       : tec_q + `CMOI_TEC_STEP;
            end else if (eng_tx_done && tec_q != 9'h000) begin
                tec_q <= tec_q - 9'h001;
            end
            if (eng_rx_err && rec_q != `CMOI_REC_MAX) rec_q <= rec_q + 8'h01;
            else if (eng_rx.valid && rec_q != 8'h00) rec_q <= rec_q - 8'h01;
        end
    end

    // ****************************************
    // bus pins
    // ****************************************
    always_ff @(posedge clk or posedge rst_int) begin
        if (rst_int) begin
            txd_q <= 1'b1;
            bus_on_q <= 1'b0;
        end else begin
            txd_q <= (state_q != ST_RUN || init_q) ? 1'b1 : eng_tx_bit;
            bus_on_q <= state_q == ST_RUN && !init_q;
        end
    end

    AST_INIT_RECESSIVE: assert property (init_q |=> txd_q && !bus_on_q)
        else $error("bus driven while init set");

    // ****************************************
    // acceptance and transmit selection
    // ****************************************
    logic [NOBJ:1] hit, pend;
    logic [3:0] rx_hit, tx_pick;
    cmoi_frame_t tx_frame;
    always_comb begin
        for (int i = 1; i <= NOBJ; i++) begin
            // xtd picks full or standard compare, dir picks frame type
            hit[i] = valid_q[i] && cfg_q[i][`CMOI_CFG_XTD] == eng_rx.frame.extended_id_select
                     && cfg_q[i][`CMOI_CFG_DIR] == eng_rx.frame.rtr
                     && (eng_rx.frame.extended_id_select ? arb_q[i] == eng_rx.frame.id
                         : arb_q[i][28:18] == eng_rx.frame.id[28:18]);
            pend[i] = valid_q[i] && transmit_request_q[i] && i != NOBJ;
        end
    end
    assign rx_hit = (eng_rx.valid && bus_on_q) ? lowest_set(hit) : 4'h0;
    assign tx_pick = lowest_set(pend);

    // direction one sends data, direction zero sends a remote frame
    always_comb begin
        tx_frame = '0;
        if (tx_pick != 4'h0) begin
            tx_frame.id = arb_q[tx_pick];
            tx_frame.extended_id_select = cfg_q[tx_pick][`CMOI_CFG_XTD];
            tx_frame.rtr = !cfg_q[tx_pick][`CMOI_CFG_DIR];
            tx_frame.data_length_code = cfg_q[tx_pick][`CMOI_CFG_DLC];
            for (int b = 0; b < 8; b++) tx_frame.data[b*8 +: 8] = db_q[tx_pick][b];
        end
    end

    always_ff @(posedge clk or posedge rst_int) begin
        if (rst_int) begin
            tx_req_q <= '0;
        end else if (!bus_on_q || (tx_req_q.valid && eng_tx_done)) begin
            tx_req_q.valid <= 1'b0;
        end else if (!tx_req_q.valid && tx_pick != 4'h0) begin
            tx_req_q <= {1'b1, tx_pick, tx_frame};
        end
    end

    AST_TX_DIR: assert property ($rose(tx_req_q.valid) |-> tx_req_q.frame.rtr ==
                                 !cfg_q[tx_req_q.obj][`CMOI_CFG_DIR]
                                 && tx_req_q.obj != 4'(NOBJ))
        else $error("transmit frame type disagrees with direction");

    // ****************************************
    // object flags, last object alternation
    // ****************************************
    logic sw_ctl;
    assign sw_ctl = wr && obj_sel && sub == `CMOI_SUB_OBJCTL && avs_byteenable[0];

    // hardware sets are applied last so they beat software clears
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            valid_q <= '0;
            transmit_request_q <= '0;
            remote_pending_q <= '0;
            new_data_flag_q <= '0;
            sel_q <= 1'b0;
            altp_q <= 1'b0;
        end else begin
            for (int i = 1; i <= NOBJ; i++) begin
                if (eng_tx_done && tx_req_q.valid && tx_req_q.obj == 4'(i)) begin
                    transmit_request_q[i] <= 1'b0;
                    remote_pending_q[i] <= 1'b0;
                end
                if (sw_ctl && obj_idx == 4'(i)) begin
                    valid_q[i] <= avs_writedata[`CMOI_OBJ_VALID];
                    transmit_request_q[i] <= avs_writedata[`CMOI_OBJ_TRANSMIT_REQUEST];
                    remote_pending_q[i] <= avs_writedata[`CMOI_OBJ_REMOTE_PENDING];
                    new_data_flag_q[i] <= avs_writedata[`CMOI_OBJ_NEW_DATA_FLAG];
                end
                if (rx_hit == 4'(i) && eng_rx.frame.rtr) begin
                    transmit_request_q[i] <= 1'b1;
                    remote_pending_q[i] <= 1'b1;
                end
                if (rx_hit == 4'(i) && !eng_rx.frame.rtr) new_data_flag_q[i] <= 1'b1;
            end
            transmit_request_q[NOBJ] <= 1'b0;
            remote_pending_q[NOBJ] <= 1'b0;
            if (init_q) begin
                new_data_flag_q[NOBJ] <= 1'b0;
                altp_q <= 1'b0;
            end else if (rx_hit == 4'(NOBJ) && new_data_flag_q[NOBJ] && !eng_rx.frame.rtr) begin
                altp_q <= 1'b1;
            end else if (altp_q && sw_ctl && obj_idx == 4'(NOBJ)
                         && !avs_writedata[`CMOI_OBJ_NEW_DATA_FLAG]) begin
                sel_q <= ~sel_q;
                altp_q <= 1'b0;
                new_data_flag_q[NOBJ] <= 1'b1;
            end
        end
    end

    AST_REMOTE_SETS: assert property (rx_hit != 4'h0 && rx_hit != 4'(NOBJ)
                                      && eng_rx.frame.rtr
                                      |=> transmit_request_q[$past(rx_hit)] && remote_pending_q[$past(rx_hit)])
        else $error("remote frame did not set request flags");
    AST_LAST_SWAP: assert property (rx_hit == 4'(NOBJ) && new_data_flag_q[NOBJ] && !init_q
                                    && !eng_rx.frame.rtr |=> altp_q && $stable(sel_q))
        else $error("second message overwrote the visible buffer");

    // ****************************************
    // object contents, not reset
    // ****************************************
    logic [3:0] rx_bank;
    assign rx_bank = bank(rx_hit, new_data_flag_q[NOBJ]);

    always_ff @(posedge clk) begin
        if (wr && obj_sel) begin
            if (sub == `CMOI_SUB_ARB) arb_q[obj_idx] <= 29'(merge({3'h0, arb_q[obj_idx]},
                                        avs_writedata, avs_byteenable));
            if (sub == `CMOI_SUB_CFG && avs_byteenable[0]) begin
                cfg_q[obj_idx] <= {clamp_dlc(avs_writedata[7:4]), avs_writedata[3:0]};
            end
            if (sub >= `CMOI_SUB_DB0 && sub <= `CMOI_SUB_DB7 && avs_byteenable[0]) begin
                db_q[bank(obj_idx, 1'b0)][3'(sub - `CMOI_SUB_DB0)] <= avs_writedata[7:0];
            end
        end
        if (rx_hit != 4'h0) begin
            cfg_q[rx_hit][`CMOI_CFG_DLC] <= clamp_dlc(eng_rx.frame.data_length_code);
            if (!eng_rx.frame.rtr) begin
                arb_q[rx_hit] <= eng_rx.frame.extended_id_select ? eng_rx.frame.id
                                 : {eng_rx.frame.id[28:18], 18'h0};
                for (int b = 0; b < 8; b++) db_q[rx_bank][b] <= eng_rx.frame.data[b*8 +: 8];
            end
        end
    end

    assign avs_readdata = readdata_q;
    assign avs_waitrequest = waitreq_q;
    assign eng_tx_req = tx_req_q;
    assign bus_transmit_output = txd_q;
    assign bus_on = bus_on_q;
    assign bit_sample = sample_q;
endmodule // cmoi_can_core
`default_nettype wire

// ==== hw/cmoi_map.svh ====
// ****************************************
// can message object / init / bit timing map
// ****************************************
`ifndef CMOI_MAP_SVH
`define CMOI_MAP_SVH
`define CMOI_ADDR_W 10
`define CMOI_IDX_CTRL 8'h00
`define CMOI_IDX_BTIME 8'h04
`define CMOI_IDX_ERRCNT 8'h05
`define CMOI_SUB_OBJCTL 4'h0
`define CMOI_SUB_ARB 4'h2
`define CMOI_SUB_CFG 4'h6
`define CMOI_SUB_DB0 4'h7
`define CMOI_SUB_DB7 4'hE
`define CMOI_CTRL_RST 8'h01
`define CMOI_CTRL_INIT 0
`define CMOI_CTRL_CCE 6
`define CMOI_LEC_BIT0 3'h5
`define CMOI_BT_RST 15'h2301
`define CMOI_BT_BRP 5:0
`define CMOI_BT_SEGMENT_BEFORE_SAMPLE 11:8
`define CMOI_BT_SEGMENT_AFTER_SAMPLE 14:12
`define CMOI_CFG_DLC 7:4
`define CMOI_CFG_DIR 3
`define CMOI_CFG_XTD 2
`define CMOI_DLC_MAX 4'h8
`define CMOI_OBJ_VALID 0
`define CMOI_OBJ_TRANSMIT_REQUEST 1
`define CMOI_OBJ_REMOTE_PENDING 2
`define CMOI_OBJ_NEW_DATA_FLAG 3
`define CMOI_IDLE_BITS 4'hB
`define CMOI_RECOVER_IDLES 8'h81
`define CMOI_TEC_STEP 9'h008
`define CMOI_TEC_BUSOFF 9'h100
`define CMOI_REC_MAX 8'hFF
`endif

// ==== hw/cmoi_pkg.sv ====
`default_nettype none
// ****************************************
// shared types
// ****************************************
package cmoi_pkg;
    // controller sequencing, gray along init-sync-run-recover
    typedef enum logic [1:0] {
        ST_INIT = 2'h0,
        ST_SYNC = 2'h1,
        ST_RUN = 2'h3,
        ST_RECOV = 2'h2
    } cmoi_state_t;
    // one can frame as exchanged with the frame engine
    typedef struct packed {
        logic [28:0] id;
        logic extended_id_select;
        logic rtr;
        logic [3:0] data_length_code;
        logic [63:0] data;
    } cmoi_frame_t;
    typedef struct packed {
        logic valid;
        logic [3:0] obj;
        cmoi_frame_t frame;
    } cmoi_txreq_t;
    typedef struct packed {
        logic valid;
        cmoi_frame_t frame;
    } cmoi_rxfrm_t;
endpackage
`default_nettype wire

// ==== test/cmoi_far_node.sv ====
`default_nettype none
// ************************
// far side frame engine
// ************************
module cmoi_far_node (
    input wire logic clk,
    input wire cmoi_pkg::cmoi_txreq_t req,
    output logic rx_pin,
    output logic tx_bit,
    output logic done,
    output var cmoi_pkg::cmoi_rxfrm_t rx
);
    timeunit 1ns;
    timeprecision 1ps;
    import cmoi_pkg::*;
    logic [2:0] cnt_q;
    // idle bus rests recessive
    initial begin
        rx_pin = 1'b1;
        tx_bit = 1'b1;
        rx = '0;
        done = 1'b0;
        cnt_q = 3'h0;
    end
    // acknowledge each request a few cycles after it appears
    always @(posedge clk) begin
        done <= req.valid && cnt_q == 3'h4;
        cnt_q <= (req.valid && !done) ? cnt_q + 3'h1 : 3'h0;
    end
    // deliver one received frame for a single cycle
    task automatic send(input cmoi_frame_t f);
        rx <= {1'b1, f};
        @(posedge clk);
        rx.valid <= 1'b0;
    endtask
endmodule // cmoi_far_node
`default_nettype wire

// ==== test/tb.sv ====
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cmoi_pkg::*;
    logic clk, rst, wdt_rst, terr, rd, wr, wreq, rxp, txb, done, bto, bon, bsmp;
    logic [9:0] addr;
    logic [31:0] wd, rdata, d;
    cmoi_rxfrm_t erx;
    cmoi_txreq_t treq;
    int error_cnt = 0, samples_checked = 0, cyc = 0, n;
    cmoi_can_core dut (.clk(clk), .rst(rst), .wdt_rst(wdt_rst), .avs_address(addr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF),
        .avs_readdata(rdata), .avs_waitrequest(wreq), .rx_pin(rxp), .eng_tx_bit(txb),
        .eng_tx_done(done), .eng_tx_err(terr), .eng_rx_err(1'b0), .eng_rx(erx),
        .eng_tx_req(treq), .bus_transmit_output(bto), .bus_on(bon), .bit_sample(bsmp));
    cmoi_far_node p (.clk(clk), .req(treq), .rx_pin(rxp), .tx_bit(txb), .done(done), .rx(erx));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one bus access, held until waitrequest is seen low
    task automatic acc(input logic w, input logic [7:0] i, input logic [31:0] v);
        @(posedge clk);
        addr <= {i, 2'b00};
        wr <= w;
        rd <= !w;
        wd <= v;
        do @(posedge clk); while (wreq !== 1'b0);
        d = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wait_tx(input logic v);
        do @(posedge clk); while (treq.valid !== v);
    endtask
    // clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // run limit
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end
    // main sequence
    initial begin
        {rst, wdt_rst, terr, rd, wr, addr, wd} = {1'b1, 46'h0};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        chk(bto, 1);
        acc(0, 8'h00, 0);
        chk(d & 32'hFF, 32'h01);
        acc(0, 8'h05, 0);
        chk(d, 0);
        acc(1, 8'h04, 32'h2300);
        acc(0, 8'h04, 0);
        chk(d, 32'h2301);
        acc(1, 8'h00, 32'h41);
        acc(1, 8'h04, 32'h2300);
        acc(0, 8'h04, 0);
        chk(d, 32'h2300);
        acc(1, 8'h16, 32'hF8);
        acc(0, 8'h16, 0);
        chk(d & 32'hFF, 32'h88);
        acc(1, 8'h17, 32'hA5);
        acc(0, 8'h17, 0);
        chk(d & 32'hFF, 32'hA5);
        acc(1, 8'h12, 32'h0048_0000);
        acc(1, 8'h10, 1);
        acc(1, 8'h22, 32'h00D0_0000);
        acc(1, 8'h26, 32'h80);
        acc(1, 8'h20, 1);
        acc(1, 8'h00, 0);
        n = 0;
        while (bon !== 1'b1) begin
            @(posedge clk);
            if (bsmp === 1'b1) n++;
        end
        chk(n >= 11, 1);
        while (bsmp !== 1'b1) @(posedge clk);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (bsmp !== 1'b1);
        chk(n, 8);
        acc(1, 8'h10, 3);
        wait_tx(1);
        chk(treq.obj, 1);
        chk(treq.frame.rtr, 0);
        wait_tx(0);
        acc(0, 8'h10, 0);
        chk(d & 32'hF, 1);
        acc(1, 8'h20, 3);
        wait_tx(1);
        chk(treq.frame.rtr, 1);
        chk(treq.frame.id, 32'h00D0_0000);
        wait_tx(0);
        p.send({29'h0D0_0000, 1'b0, 1'b0, 4'h8, 64'hC3});
        acc(0, 8'h20, 0);
        chk(d[3], 1);
        acc(0, 8'h27, 0);
        chk(d & 32'hFF, 32'hC3);
        p.send({29'h048_0000, 1'b0, 1'b1, 4'h0, 64'h0});
        wait_tx(1);
        chk(treq.obj, 1);
        wait_tx(0);
        acc(1, 8'hF2, 32'h00A0_0000);
        acc(1, 8'hF6, 32'h80);
        acc(1, 8'hF0, 1);
        p.send({29'h0A0_0000, 1'b0, 1'b0, 4'h1, 64'h11});
        @(posedge clk);
        p.send({29'h0A0_0000, 1'b0, 1'b0, 4'h1, 64'h22});
        acc(0, 8'hF7, 0);
        chk(d & 32'hFF, 32'h11);
        acc(1, 8'hF0, 1);
        acc(0, 8'hF7, 0);
        chk(d & 32'hFF, 32'h22);
        acc(0, 8'hF0, 0);
        chk(d & 32'hF, 32'h9);
        // transmit errors drive the counter into busoff
        terr <= 1'b1;
        repeat (32) @(posedge clk);
        terr <= 1'b0;
        repeat (2) @(posedge clk);
        acc(0, 8'h00, 0);
        chk(d, 32'h801);
        acc(0, 8'h05, 0);
        chk(d, 32'h100);
        acc(0, 8'hF0, 0);
        chk(d & 32'hF, 32'h1);
        acc(1, 8'h00, 0);
        n = 0;
        while (bon !== 1'b1) begin
            @(posedge clk);
            if (bsmp === 1'b1) n++;
        end
        chk(n >= 1419, 1);
        acc(0, 8'h00, 0);
        chk(d, 32'h500);
        acc(0, 8'h05, 0);
        chk(d, 0);
        wdt_rst <= 1'b1;
        repeat (2) @(posedge clk);
        wdt_rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk(bon, 0);
        chk(bto, 1);
        acc(0, 8'h00, 0);
        chk(d & 32'hFF, 32'h01);
        print_verdict();
    end
endmodule // tb
`default_nettype wire
